// File: rtl/drive_fault_and_motion_supervisor.sv
// fault detection, spindle run gating and seek gating for a cartridge disc drive
// assumes drive sense lines are asynchronous to clock; controller inputs share clock
// How it works
// - interlock fault when supplies, boards, formatter conflict or temperature switch fail
// - gain-loss fault when gain drops with heads loaded and no home seek
// - carriage-back fault when retracted and unit prepared are both active
// - write-unsettled fault when writing while heads are not settled
// - read-write clash when unselected read gate and write are both active
// - write-no-data fault when writing without write data present
// - multi-head fault when more than one head is selected
// - dc-without-write fault when head dc current flows outside write mode
// - settle limit fault if heads not settled 90 ms after seek command
// - settle limit fault if carriage not retracted 1.25 s after retract
// - settle limit fault if not home-settled 1.25 s after retract or return-home drops
// - spindle starts only with cartridge locked, no interlock or settle limit fault, run switch, carriage retracted
// - running spindle keeps going while carriage out and interlock fault clear
// - on power-up retract is released when spindle speed-up becomes active
// - cylinder seek proceeds only with heads settled and seek command present
// - seek to cylinder above the highest legal value is refused
`timescale 1ns/1ns
module drive_fault_and_motion_supervisor #(
    parameter int unsigned SEEK_MS = drive_sup_pkg::SEEK_LIMIT_MS,
    parameter int unsigned HOME_MS = drive_sup_pkg::HOME_LIMIT_MS,
    parameter int unsigned TICK_CY = drive_sup_pkg::TICK_CYCLES
) (
    // clock and reset
    input  wire logic                            clock,
    input  wire logic                            rst,
    // drive sense lines (asynchronous)
    input  wire drive_sup_pkg::sense_t           sense,
    // controller side
    input  wire logic                            seek_command,
    input  wire logic [drive_sup_pkg::CYL_W-1:0] seek_cylinder,
    input  wire logic                            return_home,
    input  wire logic                            fault_clear,
    // actuator outputs
    output logic                                 spindle_run,
    output logic                                 carriage_retract,
    output logic                                 seek_go,
    output logic [drive_sup_pkg::CYL_W-1:0]      seek_target,
    output logic                                 seek_refused,
    // fault indications
    output logic [drive_sup_pkg::FLT_N-1:0]      fault_ff,
    output logic                                 interlock_fault,
    output logic                                 settle_limit_fault
);

    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    typedef struct packed {
        drive_sup_pkg::sense_t              meta;
        drive_sup_pkg::sense_t              sync;
        logic [drive_sup_pkg::FLT_N-1:0]    flt;
        logic                               spin;
        logic                               ret;
        logic                               rh_prev;
        logic                               sk_prev;
        logic                               go;
        logic                               refused;
        logic [drive_sup_pkg::CYL_W-1:0]    target;
        drive_sup_pkg::timer_t              tmr;
    } state_t;

    state_t state_ff;
    state_t nxt_state;
    drive_sup_pkg::sense_t s;
    logic [drive_sup_pkg::FLT_N-1:0] raw;
    logic ret_drop;
    logic rh_drop;
    logic sk_rise;
    logic tick_hit;
    logic [drive_sup_pkg::MS_W-1:0] limit_ms;

    assign s = state_ff.sync;

    // -----------------------------------------------------------------
    // next state
    // -----------------------------------------------------------------
    always_comb begin
        nxt_state      = state_ff;
        // two-flop synchroniser: meta is read only by sync
        nxt_state.meta = sense;
        nxt_state.sync = state_ff.meta;

        raw = '0;
        raw[drive_sup_pkg::F_INTERLOCK]  = s.power_chain_fault;
        raw[drive_sup_pkg::F_GAIN]       = !s.gain_ok && s.heads_loaded
                                           && !(state_ff.tmr.mode == drive_sup_pkg::HOME_T);
        raw[drive_sup_pkg::F_CARR_BACK]  = s.carriage_retracted && s.unit_prepared;
        raw[drive_sup_pkg::F_WR_UNSET]   = s.write_mode && !s.heads_settled;
        raw[drive_sup_pkg::F_RW_CLASH]   = s.unselected_read_gate && s.write_mode;
        raw[drive_sup_pkg::F_WR_NODATA]  = s.write_mode && !s.write_data_present;
        raw[drive_sup_pkg::F_MULTI_HEAD] = $countones(s.head_select) > 1;
        raw[drive_sup_pkg::F_DC_NOWR]    = s.dc_current && !s.write_mode;

        // timers: one shared counter, restarted by each starting event
        rh_drop  = state_ff.rh_prev && !return_home;
        sk_rise  = seek_command && !state_ff.sk_prev;
        tick_hit = state_ff.tmr.tick_cnt == drive_sup_pkg::TICK_W'(TICK_CY - 1);
        limit_ms = (state_ff.tmr.mode == drive_sup_pkg::SEEK_T)
                   ? drive_sup_pkg::MS_W'(SEEK_MS) : drive_sup_pkg::MS_W'(HOME_MS);

        nxt_state.tmr.tick_cnt = tick_hit ? '0 : state_ff.tmr.tick_cnt + 1'b1;
        if (tick_hit && state_ff.tmr.mode != drive_sup_pkg::IDLE_T) begin
            nxt_state.tmr.ms_cnt = state_ff.tmr.ms_cnt + 1'b1;
        end
        unique case (state_ff.tmr.mode)
            drive_sup_pkg::IDLE_T: ;
            drive_sup_pkg::SEEK_T: begin
                if (s.heads_settled) nxt_state.tmr.mode = drive_sup_pkg::IDLE_T;
            end
            drive_sup_pkg::RET_T: begin
                if (s.carriage_retracted) nxt_state.tmr.mode = drive_sup_pkg::IDLE_T;
            end
            drive_sup_pkg::HOME_T: begin
                if (s.heads_settled) nxt_state.tmr.mode = drive_sup_pkg::IDLE_T;
            end
            default: nxt_state.tmr.mode = drive_sup_pkg::IDLE_T;
        endcase
        if (state_ff.tmr.mode != drive_sup_pkg::IDLE_T
            && nxt_state.tmr.mode != drive_sup_pkg::IDLE_T
            && state_ff.tmr.ms_cnt >= limit_ms) begin
            raw[drive_sup_pkg::F_SETTLE] = 1'b1;
            nxt_state.tmr.mode = drive_sup_pkg::IDLE_T;
        end

        // retract: held until spindle speed-up, reasserted when spindle stops
        if (s.spindle_speed_up && state_ff.spin) begin
            nxt_state.ret = 1'b0;
        end else if (!state_ff.spin) begin
            nxt_state.ret = 1'b1;
        end
        ret_drop = state_ff.ret && !nxt_state.ret;
        nxt_state.rh_prev = return_home;
        nxt_state.sk_prev = seek_command;

        if (sk_rise) begin
            nxt_state.tmr = '{tick_cnt: '0, ms_cnt: '0, mode: drive_sup_pkg::SEEK_T};
        end
        if (!state_ff.ret && nxt_state.ret) begin
            nxt_state.tmr = '{tick_cnt: '0, ms_cnt: '0, mode: drive_sup_pkg::RET_T};
        end
        if (ret_drop || rh_drop) begin
            nxt_state.tmr = '{tick_cnt: '0, ms_cnt: '0, mode: drive_sup_pkg::HOME_T};
        end

        // latch: set wins over clear
        nxt_state.flt = (fault_clear ? '0 : state_ff.flt) | raw;

        // spindle
        if (!state_ff.spin) begin
            nxt_state.spin = s.cartridge_locked && s.run_switch && s.carriage_retracted
                             && !state_ff.flt[drive_sup_pkg::F_INTERLOCK]
                             && !state_ff.flt[drive_sup_pkg::F_SETTLE]
                             && !raw[drive_sup_pkg::F_INTERLOCK];
        end else begin
            nxt_state.spin = !state_ff.flt[drive_sup_pkg::F_INTERLOCK]
                             && !(s.carriage_retracted && !s.run_switch);
        end

        // cylinder seek launch
        nxt_state.go      = 1'b0;
        nxt_state.refused = 1'b0;
        if (sk_rise && s.heads_settled) begin
            if (seek_cylinder > drive_sup_pkg::CYL_MAX) begin
                nxt_state.refused = 1'b1;
            end else begin
                nxt_state.go     = 1'b1;
                nxt_state.target = seek_cylinder;
            end
        end
    end

    // -----------------------------------------------------------------
    // registers
    // -----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            state_ff          <= '0;
            state_ff.ret      <= 1'b1;
            state_ff.target   <= drive_sup_pkg::CYL_HOME;
            state_ff.tmr.mode <= drive_sup_pkg::IDLE_T;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign spindle_run        = state_ff.spin;
    assign carriage_retract   = state_ff.ret;
    assign seek_go            = state_ff.go;
    assign seek_target        = state_ff.target;
    assign seek_refused       = state_ff.refused;
    assign fault_ff           = state_ff.flt;
    assign interlock_fault    = state_ff.flt[drive_sup_pkg::F_INTERLOCK];
    assign settle_limit_fault = state_ff.flt[drive_sup_pkg::F_SETTLE];

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    carriage_back_a: assert property (@(posedge clock) disable iff (rst)
        (s.carriage_retracted && s.unit_prepared) |=> fault_ff[drive_sup_pkg::F_CARR_BACK])
        else $error("carriage back fault not raised");
    wr_unsettled_a: assert property (@(posedge clock) disable iff (rst)
        (s.write_mode && !s.heads_settled) |=> fault_ff[drive_sup_pkg::F_WR_UNSET])
        else $error("write unsettled fault not raised");
    rw_clash_a: assert property (@(posedge clock) disable iff (rst)
        (s.unselected_read_gate && s.write_mode) |=> fault_ff[drive_sup_pkg::F_RW_CLASH])
        else $error("read write clash not raised");
    wr_nodata_a: assert property (@(posedge clock) disable iff (rst)
        (s.write_mode && !s.write_data_present) |=> fault_ff[drive_sup_pkg::F_WR_NODATA])
        else $error("write no data fault not raised");
    multi_head_a: assert property (@(posedge clock) disable iff (rst)
        ($countones(s.head_select) > 1) |=> fault_ff[drive_sup_pkg::F_MULTI_HEAD])
        else $error("multi head fault not raised");
    dc_nowrite_a: assert property (@(posedge clock) disable iff (rst)
        (s.dc_current && !s.write_mode) |=> fault_ff[drive_sup_pkg::F_DC_NOWR])
        else $error("dc without write fault not raised");
    interlock_set_a: assert property (@(posedge clock) disable iff (rst)
        s.power_chain_fault |=> interlock_fault)
        else $error("interlock fault not raised");
    fault_hold_a: assert property (@(posedge clock) disable iff (rst)
        (fault_ff[drive_sup_pkg::F_MULTI_HEAD] && !fault_clear)
        |=> fault_ff[drive_sup_pkg::F_MULTI_HEAD])
        else $error("fault dropped without clear");
    spin_start_a: assert property (@(posedge clock) disable iff (rst)
        (!spindle_run ##1 spindle_run) |-> $past(s.carriage_retracted) && $past(s.run_switch))
        else $error("spindle started without conditions");
    spin_stop_a: assert property (@(posedge clock) disable iff (rst)
        (spindle_run && interlock_fault) |=> !spindle_run)
        else $error("spindle kept running under interlock fault");
    seek_legal_a: assert property (@(posedge clock) disable iff (rst)
        seek_go |-> seek_target <= drive_sup_pkg::CYL_MAX)
        else $error("illegal cylinder launched");
    seek_gate_a: assert property (@(posedge clock) disable iff (rst)
        seek_go |-> $past(seek_command) && $past(s.heads_settled))
        else $error("seek launched without settle or command");

    seek_cov: cover property (@(posedge clock) disable iff (rst) seek_go);
    refuse_cov: cover property (@(posedge clock) disable iff (rst) seek_refused);
    timeout_cov: cover property (@(posedge clock) disable iff (rst) $rose(settle_limit_fault));
    spin_cov: cover property (@(posedge clock) disable iff (rst) $rose(spindle_run));

endmodule : drive_fault_and_motion_supervisor

// File: rtl/drive_sup_pkg.sv
// shared constants and carrier types for the drive fault and motion supervisor
// assumes a single 50 MHz system clock and a synchronous active-high reset
package drive_sup_pkg;

    // -----------------------------------------------------------------
    // timing
    // -----------------------------------------------------------------
    localparam int unsigned CLK_HZ         = 50_000_000;
    localparam int unsigned TICK_US        = 1000;
    localparam int unsigned TICK_CYCLES    = CLK_HZ / 1_000_000 * TICK_US;
    localparam int unsigned SEEK_LIMIT_MS  = 90;
    localparam int unsigned HOME_LIMIT_MS  = 1250;
    localparam int unsigned TICK_W         = 16;
    localparam int unsigned MS_W           = 12;

    // -----------------------------------------------------------------
    // cylinder addressing
    // -----------------------------------------------------------------
    localparam int unsigned CYL_W          = 10;
    localparam logic [9:0]  CYL_MAX        = 10'h19a;
    localparam logic [9:0]  CYL_HOME       = 10'h000;

    // -----------------------------------------------------------------
    // fault vector layout
    // -----------------------------------------------------------------
    localparam int unsigned FLT_N          = 9;
    localparam int unsigned F_INTERLOCK    = 0;
    localparam int unsigned F_GAIN         = 1;
    localparam int unsigned F_CARR_BACK    = 2;
    localparam int unsigned F_WR_UNSET     = 3;
    localparam int unsigned F_RW_CLASH     = 4;
    localparam int unsigned F_WR_NODATA    = 5;
    localparam int unsigned F_MULTI_HEAD   = 6;
    localparam int unsigned F_DC_NOWR      = 7;
    localparam int unsigned F_SETTLE       = 8;

    localparam int unsigned HEAD_N         = 4;

    typedef enum logic [3:0] {
        IDLE_T  = 4'h1,
        SEEK_T  = 4'h2,
        RET_T   = 4'h4,
        HOME_T  = 4'h8
    } timer_mode_t;

    // drive status sensed from the mechanism
    typedef struct packed {
        logic                power_chain_fault;
        logic                gain_ok;
        logic                heads_loaded;
        logic                carriage_retracted;
        logic                unit_prepared;
        logic                heads_settled;
        logic                write_mode;
        logic                unselected_read_gate;
        logic                write_data_present;
        logic                dc_current;
        logic                cartridge_locked;
        logic                run_switch;
        logic                spindle_speed_up;
        logic [HEAD_N-1:0]   head_select;
    } sense_t;

    typedef struct packed {
        logic [TICK_W-1:0]   tick_cnt;
        logic [MS_W-1:0]     ms_cnt;
        timer_mode_t         mode;
    } timer_t;

endpackage : drive_sup_pkg

// File: verification/seek_ctrl_model.sv
// controller-side model: presents seek commands and return-home to the supervisor
// assumes callers sit on a falling clock edge when they enter its tasks
`timescale 1ns/1ns
module seek_ctrl_model (
    // clock
    input  wire logic       clock,
    // drive status as the controller sees it
    input  wire logic       settled_seen,
    // commands to the drive
    output logic            seek_command,
    output logic [9:0]      seek_cylinder,
    output logic            return_home
);
    initial begin
        seek_command  = 1'b0;
        seek_cylinder = 10'h2aa;
        return_home   = 1'b0;
    end

    // force_it drops the settle courtesy so that a seek with heads unsettled can be provoked
    task automatic seek(input logic [9:0] cyl, input bit force_it);
        int n;
        for (n = 0; n < 100 && !force_it && settled_seen !== 1'b1; n++) @(negedge clock);
        seek_cylinder = cyl;
        seek_command  = 1'b1;
        @(negedge clock);
    endtask : seek

    // the old address is not left standing once the command is withdrawn;
    // one low cycle follows so that the next seek shows a fresh rising edge
    task automatic release_seek;
        @(negedge clock);
        seek_command  = 1'b0;
        seek_cylinder = ~seek_cylinder;
        @(negedge clock);
    endtask : release_seek

    task automatic home;
        return_home = 1'b1;
        repeat (2) @(negedge clock);
        return_home = 1'b0;
    endtask : home
endmodule : seek_ctrl_model

// File: verification/test_drive_fault_and_motion_supervisor.sv
// self-checking bench for the drive fault and motion supervisor
// assumes short timer parameters: 10-cycle tick, 3 and 5 tick limits
`timescale 1ns/1ns
module test_drive_fault_and_motion_supervisor;
    localparam logic [16:0] BASE = 17'h0a801;
    logic                   clock;
    logic                   rst;
    logic                   fault_clear;
    drive_sup_pkg::sense_t  sense;
    logic                   seek_command;
    logic                   return_home;
    logic [9:0]             seek_cylinder;
    logic                   spindle_run;
    logic                   carriage_retract;
    logic                   seek_go;
    logic [9:0]             seek_target;
    logic                   seek_refused;
    logic [8:0]             fault_ff;
    logic                   interlock_fault;
    logic                   settle_limit_fault;
    logic [8:0]             want;
    int                     bad_count;
    int                     samples_checked;
    int                     n;
    int                     last_tgt;
    int                     cyls[5];

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    drive_fault_and_motion_supervisor #(.SEEK_MS(3), .HOME_MS(5), .TICK_CY(10)) DUT (
        .clock(clock), .rst(rst), .sense(sense), .seek_command(seek_command),
        .seek_cylinder(seek_cylinder), .return_home(return_home), .fault_clear(fault_clear),
        .spindle_run(spindle_run), .carriage_retract(carriage_retract), .seek_go(seek_go),
        .seek_target(seek_target), .seek_refused(seek_refused), .fault_ff(fault_ff),
        .interlock_fault(interlock_fault), .settle_limit_fault(settle_limit_fault));

    seek_ctrl_model CTRL (.clock(clock), .settled_seen(sense.heads_settled),
        .seek_command(seek_command), .seek_cylinder(seek_cylinder), .return_home(return_home));

    // ------------------------------------------------------------
    // checking helpers
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test

    function automatic logic sig(input int w);
        case (w)
            0: return spindle_run;
            1: return !carriage_retract;
            2: return settle_limit_fault;
            default: return !spindle_run;
        endcase
    endfunction : sig

    task automatic wait_for(input int w, input int lim);
        for (n = 0; n < lim && sig(w) !== 1'b1; n++) @(negedge clock);
        if (n == lim) begin
            bad_count++;
            end_of_test();
        end
    endtask : wait_for

    // static fault causes seen through the sense lines
    function automatic logic [8:0] exp_flt(input drive_sup_pkg::sense_t s);
        return {1'b0, s.dc_current & ~s.write_mode, $countones(s.head_select) > 1,
                s.write_mode & ~s.write_data_present, s.unselected_read_gate & s.write_mode,
                s.write_mode & ~s.heads_settled, s.carriage_retracted & s.unit_prepared,
                s.heads_loaded & ~s.gain_ok, s.power_chain_fault};
    endfunction : exp_flt

    task automatic clear_all;
        sense       = BASE;
        repeat (4) @(negedge clock);
        fault_clear = 1'b1;
        @(negedge clock);
        fault_clear = 1'b0;
        @(negedge clock);
        chk("fault_ff cleared", fault_ff, 0);
    endtask : clear_all

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rst         = 1'b1;
        fault_clear = 1'b0;
        sense       = BASE;
        last_tgt    = 0;
        void'($urandom(34));
        repeat (10) @(negedge clock);
        chk("retract in reset", carriage_retract, 1);
        rst = 1'b0;
        @(negedge clock);
        chk("fault_ff after reset", fault_ff, 0);
        chk("spindle after reset", spindle_run, 0);
        for (int i = 0; i < 24; i++) begin
            sense = BASE ^ (17'h1df8f & 17'($urandom));
            want  = exp_flt(sense);
            repeat (5) @(negedge clock);
            chk("fault_ff raised", fault_ff, want);
            sense = BASE;
            repeat (5) @(negedge clock);
            chk("fault_ff held", fault_ff, want);
            clear_all();
        end
        cyls = '{5, 410, 411, 1023, 0};
        cyls[4] = $urandom_range(410, 0);
        foreach (cyls[i]) begin
            CTRL.seek(cyls[i][9:0], 1'b0);
            chk("seek_go", seek_go, cyls[i] <= 410);
            chk("seek_refused", seek_refused, cyls[i] > 410);
            if (cyls[i] <= 410) last_tgt = cyls[i];
            chk("seek_target", seek_target, last_tgt);
            CTRL.release_seek();
            chk("seek pulse", {seek_go, seek_refused}, 0);
        end
        sense.heads_settled = 1'b0;
        repeat (3) @(negedge clock);
        CTRL.seek(10'h007, 1'b1);
        chk("unsettled seek_go", seek_go, 0);
        CTRL.release_seek();
        repeat (10) @(negedge clock);
        chk("settle early", settle_limit_fault, 0);
        wait_for(2, 60);
        chk("seek settle limit", fault_ff, 9'h100);
        clear_all();
        sense.power_chain_fault = 1'b1;
        repeat (5) @(negedge clock);
        sense = BASE;
        sense.cartridge_locked = 1'b1;
        sense.run_switch = 1'b1;
        repeat (10) @(negedge clock);
        chk("start blocked", spindle_run, 0);
        fault_clear = 1'b1;
        @(negedge clock);
        fault_clear = 1'b0;
        wait_for(0, 20);
        chk("spindle started", spindle_run, 1);
        sense.spindle_speed_up = 1'b1;
        wait_for(1, 20);
        chk("retract released", carriage_retract, 0);
        sense.carriage_retracted = 1'b0;
        sense.run_switch = 1'b0;
        repeat (10) @(negedge clock);
        chk("spindle keeps running", spindle_run, 1);
        sense.heads_settled = 1'b0;
        CTRL.home();
        wait_for(2, 80);
        chk("home settle limit", fault_ff, 9'h100);
        sense.heads_settled = 1'b1;
        // clear the home timeout so the retract timeout is seen on its own
        fault_clear = 1'b1;
        @(negedge clock);
        fault_clear = 1'b0;
        @(negedge clock);
        chk("home limit cleared", settle_limit_fault, 0);
        sense.power_chain_fault = 1'b1;
        wait_for(3, 20);
        chk("spindle stops", spindle_run, 0);
        wait_for(2, 90);
        chk("retract limit", fault_ff, 9'h101);
        end_of_test();
    end
endmodule : test_drive_fault_and_motion_supervisor
